// [bench/host_pin_model.sv]
// host_pin_model: external side of one port, resolving pin levels from all drivers
`timescale 1ns/1ns
`default_nettype none
module host_pin_model #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_en_i,
  output logic      [W-1:0] pin_o
);
  // a pin nobody drives floats up: open-drain pins rely on an external pull-up
  always_comb begin
    for (int b = 0; b < W; b++) begin
      pin_o[b] = !oe_n_i[b] ? pin_o_i[b] : (ext_en_i[b] ? ext_i[b] : 1'b1);
    end
  end
endmodule // host_pin_model
`default_nettype wire

// [bench/tb.sv]
// tb: self-checking testbench for the i/o port configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import io_port_pkg::*;
  logic clk_i, resetn_i, win_sel, wr_s, rd_s, strobe, dp_en, ps0, ps1, prd, tp_en, rdata_oe, pmode;
  logic [7:0] addr, wdata, rdata, haddr, hd_i, hd_o, pt_a, pt_b, pt_c, latch_en, t_oe, t_out, addr_in_a;
  logic [2:0] pt_d, pd_i, pd_o, pd_oe_n, fs_d, ext_d;
  logic [7:0] pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n, pc_i, pc_o, pc_oe_n, fs_a, fs_b;
  logic [7:0] ext_a, ext_en_a;
  logic [7:0] ext_en_b, ext_en_c;
  logic [2:0] ext_en_d;
  bus_type_t bus_type;
  int num_errors = 0;
  int checked = 0;
  typedef struct packed { logic [7:0] ofs; logic [7:0] wd; logic [7:0] exp; } row_t;
  row_t rows [15] = '{
    '{OFS_MODE_A, 8'hFF, 8'hFF}, '{OFS_MODE_B, 8'h5A, 8'h5A}, '{OFS_DATA_OUT_A, 8'hC3, 8'hC3},
    '{OFS_DATA_OUT_B, 8'h3C, 8'h3C}, '{OFS_DATA_OUT_C, 8'h81, 8'h81}, '{OFS_DATA_OUT_D, 8'h05, 8'h05},
    '{OFS_DIR_A, 8'hA5, 8'hA5}, '{OFS_DIR_B, 8'h96, 8'h96}, '{OFS_DIR_C, 8'h69, 8'h69},
    '{OFS_DIR_D, 8'hFF, 8'h07}, '{OFS_DRV_A, 8'h12, 8'h12}, '{OFS_DRV_B, 8'h34, 8'h34},
    '{OFS_DRV_C, 8'hE7, 8'hE7}, '{OFS_DRV_D, 8'hFA, 8'h02}, '{8'h40, 8'hFF, 8'h00}};

  io_port_configuration u_io_port_configuration (
    .clk_i(clk_i), .resetn_i(resetn_i), .win_sel_i(win_sel), .wr_i(wr_s), .rd_i(rd_s), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(rdata_oe), .bus_type_i(bus_type), .data_port_en_i(dp_en),
    .host_addr_lo_i(haddr), .addr_strobe_i(strobe), .host_data_i(hd_i), .host_data_o(hd_o),
    .periph_select_0_i(ps0), .periph_select_1_i(ps1), .periph_rd_i(prd), .pt_oe_a_i(pt_a), .pt_oe_b_i(pt_b),
    .pt_oe_c_i(pt_c), .pt_oe_d_i(pt_d), .addr_latch_en_i(latch_en), .test_port_en_i(tp_en),
    .test_oe_c_i(t_oe), .test_out_c_i(t_out), .pin_a_i(pa_i), .pin_b_i(pb_i), .pin_c_i(pc_i), .pin_d_i(pd_i),
    .pin_a_o(pa_o), .pin_a_oe_n_o(pa_oe_n), .pin_b_o(pb_o), .pin_b_oe_n_o(pb_oe_n), .pin_c_o(pc_o),
    .pin_c_oe_n_o(pc_oe_n), .pin_d_o(pd_o), .pin_d_oe_n_o(pd_oe_n), .fast_slew_a_o(fs_a),
    .fast_slew_b_o(fs_b), .fast_slew_d_o(fs_d), .addr_in_a_o(addr_in_a), .periph_mode_o(pmode));
  host_pin_model #(.W(8)) u_model_a (.pin_o_i(pa_o), .oe_n_i(pa_oe_n), .ext_i(ext_a), .ext_en_i(ext_en_a),
    .pin_o(pa_i));
  host_pin_model #(.W(8)) u_model_b (.pin_o_i(pb_o), .oe_n_i(pb_oe_n), .ext_i(~pb_o), .ext_en_i(ext_en_b),
    .pin_o(pb_i));
  host_pin_model #(.W(8)) u_model_c (.pin_o_i(pc_o), .oe_n_i(pc_oe_n), .ext_i(~pc_o), .ext_en_i(ext_en_c),
    .pin_o(pc_i));
  host_pin_model #(.W(3)) u_model_d (.pin_o_i(pd_o), .oe_n_i(pd_oe_n), .ext_i(ext_d), .ext_en_i(ext_en_d),
    .pin_o(pd_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask

  // requests are held through the taking edge and dropped on it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    win_sel <= 1'b1;
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    win_sel <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    win_sel <= 1'b1;
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    win_sel <= 1'b0;
    rd_s <= 1'b0;
    #1;
    chk({7'h00, rdata_oe}, 8'h01);
    chk(rdata, exp);
  endtask

  // let the last write land before pins are looked at
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    {win_sel, wr_s, rd_s, strobe, dp_en, ps0, ps1, prd, tp_en} = '0;
    {addr, wdata, haddr, hd_i, pt_a, pt_b, pt_c, latch_en, t_oe, t_out, ext_a, ext_en_a} = '0;
    pt_d = 3'h0;
    ext_d = 3'h5;
    ext_en_b = 8'h00;
    ext_en_c = 8'h0F;
    ext_en_d = 3'h7;
    bus_type = BUS_MUX8;
    resetn_i = 1'b0;
    do_reset();
    settle();
    chk(pa_oe_n & pb_oe_n & pc_oe_n, 8'hFF);
    for (int i = 0; i < 15; i++) begin
      wr(rows[i].ofs, rows[i].wd);
      rd(rows[i].ofs, rows[i].exp);
    end
    $display("test register table done");
    @(posedge clk_i);
    do_reset();
    for (int i = 0; i < 15; i++) rd(rows[i].ofs, REG_RESET);
    $display("test reset values done");
    wr(OFS_DIR_A, 8'h07);
    settle();
    chk(pa_oe_n, 8'hF8);
    @(posedge clk_i);
    pt_a <= 8'h80;
    settle();
    chk(pa_oe_n, 8'h78);
    wr(OFS_DATA_OUT_A, 8'h5A);
    settle();
    chk(pa_o & 8'h87, 8'h02);
    @(posedge clk_i);
    pt_a <= 8'h00;
    wr(OFS_DIR_A, 8'hFF);
    wr(OFS_DATA_OUT_A, 8'hFF);
    wr(OFS_DRV_A, 8'hF0);
    settle();
    chk(pa_oe_n, 8'hF0);
    chk(fs_a, 8'h00);
    wr(OFS_DRV_A, 8'h0F);
    wr(OFS_DRV_B, 8'hFF);
    wr(OFS_DIR_C, 8'hFF);
    wr(OFS_DATA_OUT_C, 8'h0F);
    wr(OFS_DRV_C, 8'hFF);
    wr(OFS_DRV_D, 8'hFF);
    wr(OFS_DIR_D, 8'h07);
    wr(OFS_DATA_OUT_D, 8'h05);
    settle();
    chk(pa_oe_n, 8'h00);
    chk(fs_a & fs_b, 8'h0F);
    chk(pc_oe_n, 8'h0F);
    chk({5'h00, fs_d}, 8'h07);
    chk({5'h00, pd_oe_n}, 8'h00);
    chk({5'h00, pd_o}, 8'h05);
    $display("test direction and drive done");
    @(posedge clk_i);
    do_reset();
    haddr <= 8'h3C;
    wr(OFS_MODE_A, 8'hFF);
    wr(OFS_DIR_A, 8'hFF);
    wr(OFS_MODE_B, 8'hFF);
    wr(OFS_DIR_B, 8'hFF);
    settle();
    chk(pa_o, 8'h3C);
    chk(pb_o, 8'h3C);
    @(posedge clk_i);
    bus_type <= BUS_NONMUX8;
    settle();
    chk(pb_o, 8'h3C);
    chk(pa_o, 8'h00);
    @(posedge clk_i);
    bus_type <= BUS_MUX8;
    wr(OFS_MODE_A, 8'h00);
    settle();
    chk(pa_o, 8'h00);
    @(posedge clk_i);
    dp_en <= 1'b1;
    settle();
    chk(pa_oe_n, 8'hFF);
    @(posedge clk_i);
    dp_en <= 1'b0;
    $display("test address out and data port done");
    wr(OFS_MEM_MAP, 8'h80);
    settle();
    chk({7'h00, pmode}, 8'h01);
    chk(pa_oe_n, 8'hFF);
    @(posedge clk_i);
    ps0 <= 1'b1;
    prd <= 1'b1;
    hd_i <= 8'h96;
    settle();
    chk(pa_oe_n, 8'h00);
    chk(pa_o, 8'h96);
    @(posedge clk_i);
    prd <= 1'b0;
    ext_a <= 8'hC3;
    ext_en_a <= 8'hFF;
    settle();
    chk(hd_o, 8'hC3);
    @(posedge clk_i);
    ps0 <= 1'b0;
    wr(OFS_MEM_MAP, 8'h00);
    $display("test peripheral mode done");
    do_reset();
    tp_en <= 1'b1;
    t_oe <= 8'h0F;
    t_out <= 8'hA5;
    settle();
    chk(pc_oe_n, 8'hF0);
    chk(pc_o & 8'h0F, 8'h05);
    @(posedge clk_i);
    tp_en <= 1'b0;
    ext_a <= 8'h11;
    settle();
    chk(addr_in_a, 8'h11);
    @(posedge clk_i);
    latch_en <= 8'hFF;
    ext_a <= 8'h22;
    strobe <= 1'b1;
    @(posedge clk_i);
    strobe <= 1'b0;
    ext_a <= 8'h33;
    settle();
    chk(addr_in_a, 8'h22);
    $display("test test port and address in done");
    results();
  end
endmodule // tb
`default_nettype wire

// [src/addr_in_latch.sv]
// addr_in_latch: optional strobe latch for high-order address inputs on one port
`timescale 1ns/1ns
`default_nettype none
module addr_in_latch (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       strobe_i,
  input  wire logic [7:0] latch_en_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] addr_o
);
  logic [7:0] held_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      held_q <= 8'h00;
    end else if (strobe_i) begin
      held_q <= pin_i;
    end
  end
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_sel
      assign addr_o[b] = latch_en_i[b] ? held_q[b] : pin_i[b];
    end
  endgenerate
endmodule // addr_in_latch
`default_nettype wire

// [src/io_port_configuration.sv]
// io_port_configuration: configuration registers and pin-function logic for ports a, b, c and d
// Functional notes
// - pin output enable is direction bit ORed with the logic output-enable term.
// - latched address nibbles go to ports a and b, or port b only.
// - high address inputs accepted on port a only, optionally latched on strobe.
// - port a as data bus disables its direction, product-term, mode and data out functions; its drive select still applies.
// - memory mapping register bit 7 enables peripheral buffer mode on port a.
// - in peripheral mode port a floats unless a peripheral select and the peripheral read term are both active.
// - test-port pins may share port c with other functions.
// - host reaches configuration registers by plain reads and writes at fixed offsets.
// - each register bit except memory mapping bit 7 controls only the same-numbered pin of its port.
// - all configuration registers clear to zero at power-up.
// - mode bit zero gives host i/o, one gives latched address output.
// - mode control registers exist only for ports a and b.
// - direction one is output, zero is input; inputs after reset.
// - with product term inactive, direction bit alone sets pin direction.
// - port d direction register implements only its three low bits.
// - drive select one gives open drain on a/b bits 7-4 and all c.
// - drive select one gives fast slew on a/b bits 3-0 and d 2-0.
// - data out register drives pins when enabled, and reads back.
`timescale 1ns/1ns
`default_nettype none
module io_port_configuration
  import io_port_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  // host bus inside the configuration i/o window
  input  wire logic                    win_sel_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wdata_i,
  output logic      [DATA_W-1:0]       rdata_o,
  output logic                         rdata_oe_o,
  // bus configuration and latched host address
  input  wire io_port_pkg::bus_type_t  bus_type_i,
  input  wire logic                    data_port_en_i,
  input  wire logic [7:0]              host_addr_lo_i,
  input  wire logic                    addr_strobe_i,
  input  wire logic [7:0]              host_data_i,
  output logic      [7:0]              host_data_o,
  // decode logic array terms
  input  wire logic                    periph_select_0_i,
  input  wire logic                    periph_select_1_i,
  input  wire logic                    periph_rd_i,
  input  wire logic [7:0]              pt_oe_a_i,
  input  wire logic [7:0]              pt_oe_b_i,
  input  wire logic [7:0]              pt_oe_c_i,
  input  wire logic [2:0]              pt_oe_d_i,
  input  wire logic [7:0]              addr_latch_en_i,
  input  wire logic                    test_port_en_i,
  input  wire logic [7:0]              test_oe_c_i,
  input  wire logic [7:0]              test_out_c_i,
  // pins
  input  wire logic [7:0]              pin_a_i,
  input  wire logic [7:0]              pin_b_i,
  input  wire logic [7:0]              pin_c_i,
  input  wire logic [2:0]              pin_d_i,
  output logic      [7:0]              pin_a_o,
  output logic      [7:0]              pin_a_oe_n_o,
  output logic      [7:0]              pin_b_o,
  output logic      [7:0]              pin_b_oe_n_o,
  output logic      [7:0]              pin_c_o,
  output logic      [7:0]              pin_c_oe_n_o,
  output logic      [2:0]              pin_d_o,
  output logic      [2:0]              pin_d_oe_n_o,
  output logic      [7:0]              fast_slew_a_o,
  output logic      [7:0]              fast_slew_b_o,
  output logic      [2:0]              fast_slew_d_o,
  output logic      [7:0]              addr_in_a_o,
  output logic                         periph_mode_o
);
  import io_port_pkg::*;

  logic [7:0] mode_a_q, mode_b_q;
  logic [7:0] dir_a_q, dir_b_q, dir_c_q, dir_d_q;
  logic [7:0] drv_a_q, drv_b_q, drv_c_q, drv_d_q;
  logic [7:0] dout_a_q, dout_b_q, dout_c_q, dout_d_q;
  logic [7:0] mem_map_q;
  logic [7:0] rdata_q;
  logic       rd_q;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr_for_a, addr_for_b;
  logic [7:0] en_a, en_b, en_c;
  logic [7:0] pd_o8, pd_oe_n8;
  logic       periph_on;
  logic       periph_sel;
  logic [7:0] rd_mux;

  assign wr_en = win_sel_i & wr_i;
  assign rd_en = win_sel_i & rd_i;

  // configuration registers, cleared at reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_a_q <= REG_RESET;
      mode_b_q <= REG_RESET;
      dir_a_q  <= REG_RESET;
      dir_b_q  <= REG_RESET;
      dir_c_q  <= REG_RESET;
      dir_d_q  <= REG_RESET;
      drv_a_q  <= REG_RESET;
      drv_b_q  <= REG_RESET;
      drv_c_q  <= REG_RESET;
      drv_d_q  <= REG_RESET;
    end else if (wr_en) begin
      case (addr_i)
        OFS_MODE_A: mode_a_q <= wdata_i;
        OFS_MODE_B: mode_b_q <= wdata_i;
        OFS_DIR_A:  dir_a_q  <= wdata_i;
        OFS_DIR_B:  dir_b_q  <= wdata_i;
        OFS_DIR_C:  dir_c_q  <= wdata_i;
        OFS_DIR_D:  dir_d_q  <= wdata_i & PORT_D_MASK;
        OFS_DRV_A:  drv_a_q  <= wdata_i;
        OFS_DRV_B:  drv_b_q  <= wdata_i;
        OFS_DRV_C:  drv_c_q  <= wdata_i;
        OFS_DRV_D:  drv_d_q  <= wdata_i & PORT_D_MASK;
        default: ;
      endcase
    end
  end

  // output data registers and memory mapping register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      dout_a_q  <= REG_RESET;
      dout_b_q  <= REG_RESET;
      dout_c_q  <= REG_RESET;
      dout_d_q  <= REG_RESET;
      mem_map_q <= REG_RESET;
    end else if (wr_en) begin
      case (addr_i)
        OFS_DATA_OUT_A: dout_a_q  <= wdata_i;
        OFS_DATA_OUT_B: dout_b_q  <= wdata_i;
        OFS_DATA_OUT_C: dout_c_q  <= wdata_i;
        OFS_DATA_OUT_D: dout_d_q  <= wdata_i & PORT_D_MASK;
        OFS_MEM_MAP:    mem_map_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (addr_i)
      OFS_MODE_A:     rd_mux = mode_a_q;
      OFS_MODE_B:     rd_mux = mode_b_q;
      OFS_DIR_A:      rd_mux = dir_a_q;
      OFS_DIR_B:      rd_mux = dir_b_q;
      OFS_DIR_C:      rd_mux = dir_c_q;
      OFS_DIR_D:      rd_mux = dir_d_q;
      OFS_DRV_A:      rd_mux = drv_a_q;
      OFS_DRV_B:      rd_mux = drv_b_q;
      OFS_DRV_C:      rd_mux = drv_c_q;
      OFS_DRV_D:      rd_mux = drv_d_q;
      OFS_DATA_OUT_A: rd_mux = dout_a_q;
      OFS_DATA_OUT_B: rd_mux = dout_b_q;
      OFS_DATA_OUT_C: rd_mux = dout_c_q;
      OFS_DATA_OUT_D: rd_mux = dout_d_q;
      OFS_ENABLE_A:   rd_mux = en_a;
      OFS_ENABLE_B:   rd_mux = en_b;
      OFS_ENABLE_C:   rd_mux = en_c;
      OFS_MEM_MAP:    rd_mux = mem_map_q;
      default:        rd_mux = READ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= READ_IDLE;
      rd_q    <= 1'b0;
    end else begin
      rd_q    <= rd_en;
      rdata_q <= rd_en ? rd_mux : READ_IDLE;
    end
  end
  assign rdata_o    = rdata_q;
  assign rdata_oe_o = rd_q;

  // latched address routing by bus type
  always_comb begin
    case (bus_type_i)
      BUS_MUX8: begin
        addr_for_a = host_addr_lo_i;
        addr_for_b = host_addr_lo_i;
      end
      BUS_NONMUX8: begin
        addr_for_a = 8'h00;
        addr_for_b = host_addr_lo_i;
      end
      default: begin
        addr_for_a = 8'h00;
        addr_for_b = 8'h00;
      end
    endcase
  end

  // port a special modes: data port and peripheral buffer force the same pin behaviour
  assign periph_on     = mem_map_q[PERIPH_MODE_BIT];
  assign periph_mode_o = periph_on;
  assign periph_sel    = periph_select_0_i | periph_select_1_i;
  logic       a_force;
  logic [7:0] a_force_oe;
  logic [7:0] a_force_data;
  logic [7:0] a_mode_eff;
  assign a_force      = data_port_en_i | periph_on;
  // data port direction belongs to the host bus, so the same read term drives it
  assign a_force_oe   = {8{periph_sel & periph_rd_i}};
  assign a_force_data = host_data_i;
  assign a_mode_eff   = (bus_type_i == BUS_NONMUX8) ? 8'h00 : mode_a_q;
  assign host_data_o  = a_force ? pin_a_i : 8'h00;

  port_pin_driver u_port_a (
    .dir_i        (dir_a_q),
    .pt_oe_i      (pt_oe_a_i),
    .addr_mode_i  (a_mode_eff),
    .addr_i       (addr_for_a),
    .data_out_i   (dout_a_q),
    .open_drain_i (drv_a_q & OD_MASK_AB),
    .force_en_i   (a_force),
    .force_oe_i   (a_force_oe),
    .force_data_i (a_force_data),
    .pin_o        (pin_a_o),
    .pin_oe_n_o   (pin_a_oe_n_o),
    .drive_en_o   (en_a)
  );

  port_pin_driver u_port_b (
    .dir_i        (dir_b_q),
    .pt_oe_i      (pt_oe_b_i),
    .addr_mode_i  (mode_b_q),
    .addr_i       (addr_for_b),
    .data_out_i   (dout_b_q),
    .open_drain_i (drv_b_q & OD_MASK_AB),
    .force_en_i   (1'b0),
    .force_oe_i   (8'h00),
    .force_data_i (8'h00),
    .pin_o        (pin_b_o),
    .pin_oe_n_o   (pin_b_oe_n_o),
    .drive_en_o   (en_b)
  );

  // test port shares port c; it takes the pins only while enabled
  port_pin_driver u_port_c (
    .dir_i        (dir_c_q),
    .pt_oe_i      (pt_oe_c_i),
    .addr_mode_i  (8'h00),
    .addr_i       (8'h00),
    .data_out_i   (dout_c_q),
    .open_drain_i (drv_c_q),
    .force_en_i   (test_port_en_i),
    .force_oe_i   (test_oe_c_i),
    .force_data_i (test_out_c_i),
    .pin_o        (pin_c_o),
    .pin_oe_n_o   (pin_c_oe_n_o),
    .drive_en_o   (en_c)
  );

  port_pin_driver u_port_d (
    .dir_i        (dir_d_q),
    .pt_oe_i      ({5'h00, pt_oe_d_i}),
    .addr_mode_i  (8'h00),
    .addr_i       (8'h00),
    .data_out_i   (dout_d_q),
    .open_drain_i (8'h00),
    .force_en_i   (1'b0),
    .force_oe_i   (8'h00),
    .force_data_i (8'h00),
    .pin_o        (pd_o8),
    .pin_oe_n_o   (pd_oe_n8),
    .drive_en_o   ()
  );
  assign pin_d_o      = pd_o8[2:0];
  assign pin_d_oe_n_o = pd_oe_n8[2:0];

  assign fast_slew_a_o = drv_a_q & SLEW_MASK_AB;
  assign fast_slew_b_o = drv_b_q & SLEW_MASK_AB;
  assign fast_slew_d_o = drv_d_q[2:0];

  addr_in_latch u_addr_in_a (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .strobe_i   (addr_strobe_i),
    .latch_en_i (addr_latch_en_i),
    .pin_i      (pin_a_i),
    .addr_o     (addr_in_a_o)
  );

  // assertions
  sequence s_wr_dir_b;
    wr_en && addr_i == OFS_DIR_B;
  endsequence
  AST_OE_OR: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !a_force |-> (en_a == (dir_a_q | pt_oe_a_i)))
    else $error("port a enable is not direction or term");
  AST_DIR_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_wr_dir_b |=> dir_b_q == $past(wdata_i))
    else $error("direction write lost");
  AST_D_MASK: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dir_d_q[7:3] == 5'h00) && (drv_d_q[7:3] == 5'h00))
    else $error("port d upper bits set");
  AST_PERIPH_FLOAT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    periph_on && !periph_sel |-> pin_a_oe_n_o == 8'hFF)
    else $error("port a driven without select");
  AST_DATA_PORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    data_port_en_i && !periph_rd_i |-> pin_a_oe_n_o == 8'hFF)
    else $error("port a gpio active in data port mode");
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    !resetn_i |=> (dir_a_q == 8'h00) && (mode_a_q == 8'h00) && (drv_c_q == 8'h00))
    else $error("register not cleared by reset");
  AST_ADDR_OUT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_b_q[0] && en_b[0]) |-> pin_b_o[0] == addr_for_b[0])
    else $error("address not on port b");
  AST_READ_BACK: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_en && addr_i == OFS_DATA_OUT_C |=> rdata_o == $past(dout_c_q) && rdata_oe_o)
    else $error("data out read back wrong");
  // a nonmux bus leaves the address nibbles to port b alone
  AST_NONMUX_A: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (bus_type_i == BUS_NONMUX8) && !a_force |-> pin_a_o == dout_a_q)
    else $error("address reached port a on a nonmux bus");
  AST_SLEW_SPLIT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fast_slew_a_o[7:4] == 4'h0) && (fast_slew_b_o[7:4] == 4'h0))
    else $error("slew set on an open drain bit");
  AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (en_c[0] && drv_c_q[0] && pin_c_o[0]) |-> pin_c_oe_n_o[0])
    else $error("open drain pin driven high");
  AST_TEST_PORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    test_port_en_i |-> en_c == test_oe_c_i)
    else $error("port c not handed to the test port");
  sequence s_periph_read;
    periph_on && periph_sel && periph_rd_i;
  endsequence
  AST_PERIPH_DRIVE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_periph_read |-> (pin_a_o == host_data_i)
      && (pin_a_oe_n_o == (drv_a_q & OD_MASK_AB & host_data_i)))
    else $error("port a does not buffer host data");
endmodule // io_port_configuration
`default_nettype wire

// [src/io_port_pkg.sv]
// package: register offsets, reset values and mode encodings for the i/o port configuration block
package io_port_pkg;
  localparam int unsigned         ADDR_W          = 8;
  localparam int unsigned         DATA_W          = 8;
  // offsets within the configuration i/o window
  localparam logic [7:0]          OFS_DATA_OUT_A  = 8'h04;
  localparam logic [7:0]          OFS_DATA_OUT_B  = 8'h05;
  localparam logic [7:0]          OFS_MODE_A      = 8'h02;
  localparam logic [7:0]          OFS_MODE_B      = 8'h03;
  localparam logic [7:0]          OFS_DATA_OUT_C  = 8'h12;
  localparam logic [7:0]          OFS_DATA_OUT_D  = 8'h13;
  localparam logic [7:0]          OFS_DIR_A       = 8'h06;
  localparam logic [7:0]          OFS_DIR_B       = 8'h07;
  localparam logic [7:0]          OFS_DIR_C       = 8'h14;
  localparam logic [7:0]          OFS_DIR_D       = 8'h15;
  localparam logic [7:0]          OFS_DRV_A       = 8'h08;
  localparam logic [7:0]          OFS_DRV_B       = 8'h09;
  localparam logic [7:0]          OFS_DRV_C       = 8'h16;
  localparam logic [7:0]          OFS_DRV_D       = 8'h17;
  localparam logic [7:0]          OFS_ENABLE_A    = 8'h0C;
  localparam logic [7:0]          OFS_ENABLE_B    = 8'h0D;
  localparam logic [7:0]          OFS_ENABLE_C    = 8'h1A;
  localparam logic [7:0]          OFS_MEM_MAP     = 8'hE2;
  localparam logic [7:0]          REG_RESET       = 8'h00;
  localparam int unsigned         PERIPH_MODE_BIT = 7;
  localparam int unsigned         PORT_D_PINS     = 3;
  localparam logic [7:0]          PORT_D_MASK     = 8'h07;
  // split of the a/b drive select register: upper nibble open drain, lower slew
  localparam logic [7:0]          OD_MASK_AB      = 8'hF0;
  localparam logic [7:0]          SLEW_MASK_AB    = 8'h0F;
  localparam logic [7:0]          READ_IDLE       = 8'h00;
  typedef enum logic [1:0] {
    BUS_MUX8,
    BUS_NONMUX8
  } bus_type_t;
endpackage

// [src/port_pin_driver.sv]
// port_pin_driver: per-bit output enable, drive type and source mux for one 8-pin port
`timescale 1ns/1ns
`default_nettype none
module port_pin_driver (
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] pt_oe_i,
  input  wire logic [7:0] addr_mode_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] data_out_i,
  input  wire logic [7:0] open_drain_i,
  input  wire logic       force_en_i,
  input  wire logic [7:0] force_oe_i,
  input  wire logic [7:0] force_data_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_n_o,
  output logic      [7:0] drive_en_o
);
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic oe;
      logic val;
      // direction or product term, one bit per pin
      assign oe  = force_en_i ? force_oe_i[b] : (dir_i[b] | pt_oe_i[b]);
      assign val = force_en_i ? force_data_i[b] : (addr_mode_i[b] ? addr_i[b] : data_out_i[b]);
      assign drive_en_o[b] = oe;
      assign pin_o[b]      = val;
      // an open-drain pin only pulls low; a high is left to the external pull-up
      assign pin_oe_n_o[b] = ~(oe & (~open_drain_i[b] | ~val));
    end
  endgenerate
endmodule // port_pin_driver
`default_nettype wire
